// ---- logic/user_flash_regs.vh ----
// Constants for the user flash serial access block
`ifndef USER_FLASH_REGS_VH
`define USER_FLASH_REGS_VH
`define UF_ADDR_W         9
`define UF_DATA_W         16
`define UF_WORDS          512
`define UF_SECTOR_BITS    4096
`define UF_SECTOR_WORDS   256
`define UF_ADDR_MAX       9'h1FF
`define UF_SECTOR1_BASE   9'h100
`define UF_SECTOR_BIT     8
`define UF_ERASED_WORD    16'hFFFF
`define UF_CLK_PERIOD_NS  8
`define UF_PROG_TIME_NS   75000
`define UF_PROG_CYCLES    ((`UF_PROG_TIME_NS + `UF_CLK_PERIOD_NS - 1) / `UF_CLK_PERIOD_NS)
`define UF_ERASE_CYCLES   256
`endif

// ---- logic/pin_sync.v ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module pin_sync (
   input  wire CLOCK_I,
   input  wire RST_I,
   input  wire pin_i,
   output reg  level_o,
   output reg  rise_o,
   output reg  fall_o
);
   reg meta_ff;
   reg s2_ff;
   reg s3_ff;
   always @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         meta_ff <= 1'b0;
         s2_ff   <= 1'b0;
         s3_ff   <= 1'b0;
         level_o <= 1'b0;
         rise_o  <= 1'b0;
         fall_o  <= 1'b0;
      end else begin
         meta_ff <= pin_i;
         s2_ff   <= meta_ff;
         s3_ff   <= s2_ff;
         rise_o  <= 1'b0;
         fall_o  <= 1'b0;
         // Level changes only once stages two and three agree
         if (s2_ff == s3_ff && s3_ff != level_o) begin
            level_o <= s3_ff;
            rise_o  <= s3_ff;
            fall_o  <= ~s3_ff;
         end
      end
   end
endmodule // pin_sync

// ---- logic/flash_array.v ----
// Flip-flop model of the two-sector user flash storage
`timescale 1ns/1ns
`include "user_flash_regs.vh"
module flash_array #(
   parameter ADDR_W = `UF_ADDR_W,
   parameter DATA_W = `UF_DATA_W
) (
   input  wire              CLOCK_I,
   input  wire              RST_I,
   input  wire [ADDR_W-1:0] rd_addr_i,
   output wire [DATA_W-1:0] rd_data_o,
   input  wire              wr_en_i,
   input  wire [ADDR_W-1:0] wr_addr_i,
   input  wire [DATA_W-1:0] wr_data_i,
   input  wire              erase_en_i,
   input  wire              erase_sector_i
);
   localparam WORDS = 1 << ADDR_W;
   reg [DATA_W-1:0] mem_ff [0:WORDS-1];
   assign rd_data_o = mem_ff[rd_addr_i];
   genvar g;
   generate
      for (g = 0; g < WORDS; g = g + 1) begin : g_word
         always @(posedge CLOCK_I or posedge RST_I) begin
            if (RST_I) begin
               mem_ff[g] <= `UF_ERASED_WORD;
            // Sector erase hits only the half chosen by the top bit
            end else if (erase_en_i && (g / (WORDS/2)) == erase_sector_i) begin
               mem_ff[g] <= `UF_ERASED_WORD;
            end else if (wr_en_i && wr_addr_i == g) begin
               // Flash programming can only clear bits
               mem_ff[g] <= mem_ff[g] & wr_data_i;
            end
         end
      end
   endgenerate
endmodule // flash_array

// ---- logic/user_flash_serial_access.v ----
// Serial address and data register access to the user flash
`timescale 1ns/1ns
`include "user_flash_regs.vh"
module user_flash_serial_access #(
   parameter PROG_CYCLES  = `UF_PROG_CYCLES,
   parameter ERASE_CYCLES = `UF_ERASE_CYCLES
) (
   input  wire CLOCK_I,
   input  wire RST_I,
   input  wire DATA_SERIAL_IN_I,
   input  wire DATA_REG_CLOCK_I,
   input  wire DATA_SHIFT_SELECT_I,
   input  wire ADDR_SERIAL_IN_I,
   input  wire ADDR_REG_CLOCK_I,
   input  wire ADDR_SHIFT_SELECT_I,
   input  wire PROGRAM_I,
   input  wire ERASE_I,
   output reg  DATA_SERIAL_OUT_O,
   output reg  BUSY_O
);
   //--------------------------------------------------------------
   // Input synchronisers
   //--------------------------------------------------------------
   wire dclk_rise;
   wire aclk_rise;
   wire prog_rise;
   wire erase_rise;
   wire dsi_lvl;
   wire dsel_lvl;
   wire asi_lvl;
   wire asel_lvl;

   // Four cycles of latency buy settling time on every pin
   pin_sync u_dclk (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (DATA_REG_CLOCK_I),
      .level_o (),
      .rise_o  (dclk_rise),
      .fall_o  ()
   );

   pin_sync u_aclk (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (ADDR_REG_CLOCK_I),
      .level_o (),
      .rise_o  (aclk_rise),
      .fall_o  ()
   );

   pin_sync u_prog (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (PROGRAM_I),
      .level_o (),
      .rise_o  (prog_rise),
      .fall_o  ()
   );

   pin_sync u_erase (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (ERASE_I),
      .level_o (),
      .rise_o  (erase_rise),
      .fall_o  ()
   );

   // Data pins pass the same three stages, so they line up with clocks
   pin_sync u_dsi (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (DATA_SERIAL_IN_I),
      .level_o (dsi_lvl),
      .rise_o  (),
      .fall_o  ()
   );

   pin_sync u_dsel (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (DATA_SHIFT_SELECT_I),
      .level_o (dsel_lvl),
      .rise_o  (),
      .fall_o  ()
   );

   pin_sync u_asi (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (ADDR_SERIAL_IN_I),
      .level_o (asi_lvl),
      .rise_o  (),
      .fall_o  ()
   );

   pin_sync u_asel (
      .CLOCK_I (CLOCK_I),
      .RST_I   (RST_I),
      .pin_i   (ADDR_SHIFT_SELECT_I),
      .level_o (asel_lvl),
      .rise_o  (),
      .fall_o  ()
   );

   //--------------------------------------------------------------
   // Storage
   //--------------------------------------------------------------
   reg  [`UF_ADDR_W-1:0] addr_ff;
   reg  [`UF_DATA_W-1:0] data_ff;
   wire [`UF_DATA_W-1:0] rd_word;
   reg                   wr_en_ff;
   reg                   erase_en_ff;
   reg                   erase_sec_ff;
   // Operands are taken at the request, so late clocking cannot move them
   reg  [`UF_ADDR_W-1:0] wr_addr_ff;
   reg  [`UF_DATA_W-1:0] wr_data_ff;

   flash_array #(.ADDR_W(`UF_ADDR_W), .DATA_W(`UF_DATA_W)) u_array (
      .CLOCK_I        (CLOCK_I),
      .RST_I          (RST_I),
      .rd_addr_i      (addr_ff),
      .rd_data_o      (rd_word),
      .wr_en_i        (wr_en_ff),
      .wr_addr_i      (wr_addr_ff),
      .wr_data_i      (wr_data_ff),
      .erase_en_i     (erase_en_ff),
      .erase_sector_i (erase_sec_ff)
   );

   //--------------------------------------------------------------
   // Address register
   //--------------------------------------------------------------
   reg [`UF_ADDR_W-1:0] nxt_addr;
   always @* begin
      nxt_addr = addr_ff;
      if (aclk_rise) begin
         if (asel_lvl) begin
            nxt_addr = {addr_ff[`UF_ADDR_W-2:0], asi_lvl};
         end else begin
            nxt_addr = addr_ff + 9'h001;
         end
      end
   end

   //--------------------------------------------------------------
   // Data register
   //--------------------------------------------------------------
   reg [`UF_DATA_W-1:0] nxt_data;
   always @* begin
      nxt_data = data_ff;
      if (dclk_rise) begin
         if (dsel_lvl) begin
            nxt_data = {data_ff[`UF_DATA_W-2:0], dsi_lvl};
         end else begin
            nxt_data = rd_word;
         end
      end
   end

   //--------------------------------------------------------------
   // Program and erase sequencer
   //--------------------------------------------------------------
   localparam ST_IDLE  = 2'b00;
   localparam ST_PROG  = 2'b01;
   localparam ST_ERASE = 2'b10;
   reg [1:0]  state_ff;
   reg [1:0]  nxt_state;
   reg [31:0] cnt_ff;
   reg [31:0] nxt_cnt;
   reg        nxt_wr;
   reg        nxt_erase;
   reg [`UF_ADDR_W-1:0] nxt_wr_addr;
   reg [`UF_DATA_W-1:0] nxt_wr_data;
   reg                  nxt_erase_sec;

   function sector_of;
      input [`UF_ADDR_W-1:0] addr;
      begin
         sector_of = addr[`UF_SECTOR_BIT];
      end
   endfunction

   always @* begin
      nxt_state     = state_ff;
      nxt_cnt       = cnt_ff;
      nxt_wr        = 1'b0;
      nxt_erase     = 1'b0;
      nxt_wr_addr   = wr_addr_ff;
      nxt_wr_data   = wr_data_ff;
      nxt_erase_sec = erase_sec_ff;
      case (state_ff)
         ST_IDLE: begin
            // Requests seen in ST_PROG or ST_ERASE fall through and are dropped
            if (prog_rise) begin
               nxt_state   = ST_PROG;
               nxt_cnt     = PROG_CYCLES;
               nxt_wr_addr = addr_ff;
               nxt_wr_data = data_ff;
            end else if (erase_rise) begin
               nxt_state     = ST_ERASE;
               nxt_cnt       = ERASE_CYCLES;
               nxt_erase_sec = sector_of(addr_ff);
            end
         end
         ST_PROG: begin
            if (cnt_ff <= 32'h0000_0001) begin
               nxt_wr    = 1'b1;
               nxt_state = ST_IDLE;
            end
            nxt_cnt = cnt_ff - 32'h0000_0001;
         end
         ST_ERASE: begin
            if (cnt_ff <= 32'h0000_0001) begin
               nxt_erase = 1'b1;
               nxt_state = ST_IDLE;
            end
            nxt_cnt = cnt_ff - 32'h0000_0001;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         addr_ff           <= 9'h000;
         data_ff           <= 16'h0000;
         state_ff          <= ST_IDLE;
         cnt_ff            <= 32'h0000_0000;
         wr_en_ff          <= 1'b0;
         erase_en_ff       <= 1'b0;
         erase_sec_ff      <= 1'b0;
         wr_addr_ff        <= 9'h000;
         wr_data_ff        <= 16'h0000;
      end else begin
         addr_ff      <= nxt_addr;
         data_ff      <= nxt_data;
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         wr_en_ff     <= nxt_wr;
         erase_en_ff  <= nxt_erase;
         erase_sec_ff <= nxt_erase_sec;
         wr_addr_ff   <= nxt_wr_addr;
         wr_data_ff   <= nxt_wr_data;
      end
   end

   //--------------------------------------------------------------
   // Output registers
   //--------------------------------------------------------------
   always @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         BUSY_O            <= 1'b0;
         DATA_SERIAL_OUT_O <= 1'b0;
      end else begin
         // Busy covers the commit cycle too
         BUSY_O            <= (nxt_state != ST_IDLE) | nxt_wr | nxt_erase;
         DATA_SERIAL_OUT_O <= nxt_data[`UF_DATA_W-1];
      end
   end
endmodule // user_flash_serial_access

// ---- bench/user_flash_serial_access_checker.sv ----
// Port-level timing checks for the user flash serial access block
`timescale 1ns/1ns
module user_flash_serial_access_checker #(
   parameter PROG_CYCLES  = 20,
   parameter ERASE_CYCLES = 20
) (
   input wire CLOCK_I,
   input wire RST_I,
   input wire DATA_REG_CLOCK_I,
   input wire ADDR_REG_CLOCK_I,
   input wire PROGRAM_I,
   input wire ERASE_I,
   input wire DATA_SERIAL_OUT_O,
   input wire BUSY_O
);
   localparam int MAXB = 2 +
      (PROG_CYCLES > ERASE_CYCLES ? PROG_CYCLES : ERASE_CYCLES);
   logic        dck_ff;
   logic        req_ff;
   logic [4:0]  dage_ff;
   logic [3:0]  rage_ff;
   logic [15:0] bcnt_ff;
   // Ages saturate so a long idle never wraps into a false match
   always @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         dck_ff <= 1'b0;
         req_ff <= 1'b0;
         dage_ff <= 5'h1F;
         rage_ff <= 4'hF;
         bcnt_ff <= 16'h0000;
      end else begin
         dck_ff <= DATA_REG_CLOCK_I;
         req_ff <= PROGRAM_I | ERASE_I;
         dage_ff <= (DATA_REG_CLOCK_I & ~dck_ff) ? 5'h00 :
                    dage_ff + {4'h0, dage_ff != 5'h1F};
         rage_ff <= ((PROGRAM_I | ERASE_I) & ~req_ff) ? 4'h0 :
                    rage_ff + {3'h0, rage_ff != 4'hF};
         bcnt_ff <= BUSY_O ? bcnt_ff + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   AST_BUSY_PROG: assert property ($rose(PROGRAM_I) && !BUSY_O
      |-> ##[3:8] BUSY_O) else $error("no busy after program");
   AST_BUSY_ERASE: assert property ($rose(ERASE_I) && !BUSY_O
      |-> ##[3:8] BUSY_O) else $error("no busy after erase");
   AST_BUSY_CAUSE: assert property ($rose(BUSY_O)
      |-> rage_ff <= 4'h8) else $error("busy without request");
   AST_BUSY_MIN: assert property ($rose(BUSY_O)
      |-> BUSY_O[*8]) else $error("busy too short");
   AST_BUSY_MAX: assert property (bcnt_ff <= MAXB)
      else $error("busy too long");
   AST_DOUT_TIMING: assert property ($changed(DATA_SERIAL_OUT_O)
      |-> dage_ff inside {[2:8]}) else $error("output moved off edge");
   AST_DOUT_SETTLES: assert property ($rose(DATA_REG_CLOCK_I)
      |-> ##[9:10] $stable(DATA_SERIAL_OUT_O)[*3])
      else $error("output not settled");
   AST_ADDR_QUIET: assert property ($rose(ADDR_REG_CLOCK_I)
      && dage_ff == 5'h1F |=> $stable(DATA_SERIAL_OUT_O)[*8])
      else $error("address clock moved data output");
endmodule // user_flash_serial_access_checker
bind user_flash_serial_access user_flash_serial_access_checker #(
   .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) i_chk (
   .CLOCK_I(CLOCK_I), .RST_I(RST_I), .DATA_REG_CLOCK_I(DATA_REG_CLOCK_I),
   .ADDR_REG_CLOCK_I(ADDR_REG_CLOCK_I), .PROGRAM_I(PROGRAM_I),
   .ERASE_I(ERASE_I), .DATA_SERIAL_OUT_O(DATA_SERIAL_OUT_O),
   .BUSY_O(BUSY_O));

// ---- bench/fabric_bridge_model.sv ----
// Fabric-side bridge model driving the serial flash pins
`timescale 1ns/1ns
module fabric_bridge_model (
   input  wire  clk_i,
   input  wire  dout_i,
   input  wire  busy_i,
   output logic dclk_o,
   output logic dsel_o,
   output logic din_o,
   output logic aclk_o,
   output logic asel_o,
   output logic ain_o
);
   initial begin
      {dclk_o, dsel_o, din_o, aclk_o, asel_o, ain_o} = 6'h00;
   end
   // fixed 80 ns period, never clocked while busy
   task automatic pulse(input logic dat, input logic sel,
                        input logic bv, output logic seen);
      begin
         while (busy_i) @(negedge clk_i);
         @(negedge clk_i);
         if (dat) {dsel_o, din_o} = {sel, bv};
         else {asel_o, ain_o} = {sel, bv};
         repeat (4) @(negedge clk_i);
         seen = dout_i;
         if (dat) dclk_o = 1'b1;
         else aclk_o = 1'b1;
         repeat (5) @(negedge clk_i);
         {dclk_o, aclk_o} = 2'b00;
         // Released lines toggle so a stale bit cannot pass
         {din_o, ain_o} = ~{din_o, ain_o};
      end
   endtask
   // new word in MSB first, old word out MSB first
   task automatic shift_word(input logic [15:0] wi,
                             output logic [15:0] wo);
      integer i;
      begin
         for (i = 15; i >= 0; i--) pulse(1'b1, 1'b1, wi[i], wo[i]);
      end
   endtask
   task automatic set_addr(input logic [8:0] a);
      integer i;
      logic   s;
      begin
         for (i = 8; i >= 0; i--) pulse(1'b0, 1'b1, a[i], s);
      end
   endtask
endmodule // fabric_bridge_model

// ---- bench/tb_user_flash_serial_access.sv ----
// Self-checking bench for the user flash serial access block
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_user_flash_serial_access;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        prog = 1'b0;
   logic        erase = 1'b0;
   logic [15:0] w;
   logic        s;
   integer      failures = 0;
   integer      cmp_count = 0;
   wire         dclk, dsel, din, aclk, asel, ain, dout, busy;
   always #4 clk = ~clk;
   user_flash_serial_access #(.PROG_CYCLES(20), .ERASE_CYCLES(20)) i_dut (
      .CLOCK_I(clk), .RST_I(rst), .DATA_SERIAL_IN_I(din),
      .DATA_REG_CLOCK_I(dclk), .DATA_SHIFT_SELECT_I(dsel),
      .ADDR_SERIAL_IN_I(ain), .ADDR_REG_CLOCK_I(aclk),
      .ADDR_SHIFT_SELECT_I(asel), .PROGRAM_I(prog), .ERASE_I(erase),
      .DATA_SERIAL_OUT_O(dout), .BUSY_O(busy));
   fabric_bridge_model i_bridge (.clk_i(clk), .dout_i(dout), .busy_i(busy),
      .dclk_o(dclk), .dsel_o(dsel), .din_o(din), .aclk_o(aclk),
      .asel_o(asel), .ain_o(ain));
   task automatic read_cur(input logic [15:0] exp);
      begin
         i_bridge.pulse(1'b1, 1'b0, 1'b0, s);
         i_bridge.shift_word(16'h0000, w);
         `CHK(w, exp)
      end
   endtask
   task automatic read_at(input logic [8:0] a, input logic [15:0] exp);
      begin
         i_bridge.set_addr(a);
         read_cur(exp);
      end
   endtask
   task automatic strobe(input logic is_prog);
      integer n;
      begin
         @(negedge clk);
         if (is_prog) prog = 1'b1;
         else erase = 1'b1;
         repeat (7) @(negedge clk);
         `CHK(busy, 1'b1)
         {prog, erase} = 2'b00;
         for (n = 0; busy === 1'b1 && n < 100; n++) @(negedge clk);
         `CHK(busy, 1'b0)
      end
   endtask
   task automatic t_shift_through();
      begin
         read_cur(16'hFFFF);
         i_bridge.shift_word(16'hA5C3, w);
         i_bridge.shift_word(16'h3C5A, w);
         `CHK(w, 16'hA5C3)
         i_bridge.shift_word(16'h0000, w);
         `CHK(w, 16'h3C5A)
      end
   endtask
   task automatic prog_word(input logic [8:0] a, input logic [15:0] d);
      begin
         i_bridge.set_addr(a);
         i_bridge.shift_word(d, w);
         strobe(1'b1);
      end
   endtask
   task automatic t_program();
      begin
         prog_word(9'h0FF, 16'h1234);
         prog_word(9'h100, 16'h5678);
         prog_word(9'h000, 16'h00AA);
         read_at(9'h0FF, 16'h1234);
         read_at(9'h100, 16'h5678);
         read_at(9'h000, 16'h00AA);
      end
   endtask
   task automatic t_increment();
      begin
         i_bridge.set_addr(9'h0FE);
         i_bridge.pulse(1'b0, 1'b0, 1'b0, s);
         read_cur(16'h1234);
         i_bridge.set_addr(9'h1FF);
         i_bridge.pulse(1'b0, 1'b0, 1'b0, s);
         read_cur(16'h00AA);
      end
   endtask
   task automatic t_erase();
      begin
         i_bridge.set_addr(9'h1A5);
         strobe(1'b0);
         read_at(9'h100, 16'hFFFF);
         read_at(9'h0FF, 16'h1234);
         read_at(9'h000, 16'h00AA);
      end
   endtask
   task automatic stop_test();
      begin
         $display("failures=%0d comparisons=%0d", failures, cmp_count);
         if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #400000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      t_shift_through();
      t_program();
      t_increment();
      t_erase();
      stop_test();
   end
endmodule // tb_user_flash_serial_access
